// file: bench/bus_partner.sv
// two-wire bus master model that drives the serial clock and data lines
`timescale 1ns/100ps
module bus_partner (
  output logic scl,
  output logic sda
);
  // quarter of the 125 ns link clock; the clock stands high between frames
  real q = 31.25;

  // released lines float high through the pull-ups
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // start or restart: data falls while the clock is high
  task start_c;
    sda = 1'b1;
    #q scl = 1'b1;
    #q sda = 1'b0;
    #q scl = 1'b0;
    #q;
  endtask

  // one clock, data set up while the clock is low
  task bit_c(input logic b);
    sda = b;
    #q scl = 1'b1;
    #(2*q) scl = 1'b0;
    #q;
  endtask

  // eight data clocks then the ninth; ack pulls data low at the ninth
  task byte_c(input logic [7:0] d, input logic ack);
    for (int i = 7; i >= 0; i--) bit_c(d[i]);
    bit_c(!ack);
  endtask

  // stop: data rises while the clock is high, clock then stands still
  task stop_c;
    sda = 1'b0;
    #q scl = 1'b1;
    #q sda = 1'b1;
    #q;
  endtask
endmodule // bus_partner

// file: bench/tb.sv
// self-checking bench of the two-wire bus status monitor
`timescale 1ns/100ps
`include "i2c_mon_map.svh"
module tb;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [17:0] awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  logic        scl, sda, smc, dfc, cl0, irq;
  int          fails = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  i2c_status_and_line_monitor i_i2c_status_and_line_monitor (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .serial_clock_pin(scl), .serial_data_pin(sda),
    .speed_select_bit(smc), .glitch_filter_on(dfc), .rate_select_bit(cl0), .irq(irq));
  bus_partner i_bus_partner (.scl(scl), .sda(sda));

  // 4 ns clock
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // hang guard: the whole run needs under two thousand cycles
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task results;
    $display("checks %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  // write: address and data offered together, each dropped when taken
  task wr(input logic [15:0] idx, input logic [7:0] d);
    logic a, w;
    a = 1'b1;
    w = 1'b1;
    awaddr  <= {idx, 2'b00};
    wdata   <= {24'h000000, d};
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (a || w) begin
      @(posedge aclk);
      if (a && awready) begin
        a = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task rd(input logic [15:0] idx);
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    v = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  // pin changes need the synchroniser's lag before they show
  task settle;
    repeat (10) @(posedge aclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task t_reset;
    rd(`IDX_CLKSEL);
    chk("clksel reset", 32'h00, v);
    wr(`IDX_STATUS, 8'h07);
    rd(`IDX_STATUS);
    chk("status after write", 32'h00, v);
    wr(16'h0000, 8'h01);
    chk("unmapped write resp", `RESP_SLVERR, r);
    rd(16'h0000);
    chk("unmapped read resp", `RESP_SLVERR, r);
    $display("test reset done");
  endtask

  // read-only level bits ignore writes and read 0 while disabled
  task t_clksel;
    wr(`IDX_CLKSEL, 8'hFF);
    rd(`IDX_CLKSEL);
    chk("clksel all ones", 32'h0D, v);
    chk("speed high", 1'b1, smc);
    chk("filter on", 1'b1, dfc);
    chk("rate bit", 1'b1, cl0);
    wr(`IDX_CLKSEL, 8'h00);
    chk("speed standard", 1'b0, smc);
    $display("test clksel done");
  endtask

  // line levels follow the pins only while enabled
  task t_levels;
    wr(`IDX_CTRL, 8'h80);
    settle();
    rd(`IDX_CLKSEL);
    chk("levels idle", 32'h30, v);
    i_bus_partner.sda <= 1'b0;
    settle();
    rd(`IDX_CLKSEL);
    chk("levels data low", 32'h20, v);
    i_bus_partner.scl <= 1'b0;
    settle();
    rd(`IDX_CLKSEL);
    chk("levels both low", 32'h00, v);
    i_bus_partner.stop_c();
    $display("test levels done");
  endtask

  // flag set and clear events along a transfer; stop raises the interrupt
  task t_transfer;
    rd(`IDX_INT_ST);
    chk("int status from levels", 32'h03, v);
    wr(`IDX_INT_MASK, 8'h01);
    i_bus_partner.start_c();
    rd(`IDX_STATUS);
    chk("after start", 32'h03, v);
    chk("irq masked", 1'b0, irq);
    i_bus_partner.byte_c(8'hA0, 1'b1);
    rd(`IDX_STATUS);
    chk("after address ack", 32'h06, v);
    i_bus_partner.bit_c(1'b1);
    rd(`IDX_STATUS);
    chk("next first clock", 32'h00, v);
    i_bus_partner.stop_c();
    rd(`IDX_STATUS);
    chk("after stop", 32'h01, v);
    chk("irq on stop", 1'b1, irq);
    rd(`IDX_INT_ST);
    chk("int status", 32'h07, v);
    repeat (3) @(posedge aclk);
    chk("irq cleared", 1'b0, irq);
    i_bus_partner.start_c();
    i_bus_partner.byte_c(8'hA0, 1'b0);
    rd(`IDX_STATUS);
    chk("address no ack", 32'h02, v);
    $display("test transfer done");
  endtask

  // release strobe clears the start and ack flags, unit disable clears all three
  task t_release;
    i_bus_partner.start_c();
    i_bus_partner.byte_c(8'hA0, 1'b1);
    wr(`IDX_CTRL, 8'hC0);
    rd(`IDX_STATUS);
    chk("after release", 32'h00, v);
    i_bus_partner.stop_c();
    i_bus_partner.start_c();
    i_bus_partner.byte_c(8'hA0, 1'b1);
    wr(`IDX_CTRL, 8'h00);
    rd(`IDX_STATUS);
    chk("after disable", 32'h00, v);
    i_bus_partner.stop_c();
    settle();
    rd(`IDX_CLKSEL);
    chk("levels disabled", 32'h00, v);
    $display("test release done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // reset for five cycles, then the scenarios in order
  initial begin
    aresetn = 1'b0;
    awvalid = 1'b0;
    wvalid  = 1'b0;
    bready  = 1'b0;
    arvalid = 1'b0;
    rready  = 1'b0;
    awaddr  = 18'h00000;
    araddr  = 18'h00000;
    wdata   = 32'h00000000;
    wstrb   = 4'h0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_clksel();
    t_levels();
    t_transfer();
    t_release();
    results();
  end
endmodule // tb

// file: verilog/i2c_mon_map.svh
// register map, field positions and counts of the two-wire bus status monitor
`ifndef I2C_MON_MAP_SVH
`define I2C_MON_MAP_SVH

// register indices; byte address is four times the index
`define IDX_CTRL      16'hFFA8
`define IDX_STATUS    16'hFFA9
`define IDX_CLKSEL    16'hFFAA
`define IDX_INT_ST    16'hFFAB
`define IDX_INT_MASK  16'hFFAC

// bus control fields
`define CTRL_REL_BIT  6
`define CTRL_EN_BIT   7

// clock select fields
`define CLK_CL0_BIT   0
`define CLK_DFC_BIT   2
`define CLK_SMC_BIT   3
`define CLK_DAD_BIT   4
`define CLK_CLD_BIT   5
`define CLK_WR_MASK   8'h0D
`define CLK_RESET     8'h00

// bus status and interrupt fields
`define ST_STOP_BIT   0
`define ST_START_BIT  1
`define ST_ACK_BIT    2

// clock counting within a byte
`define CNT_ZERO      4'h0
`define CNT_ONE       4'h1
`define CNT_NINTH     4'h8
`define CNT_LAST      4'h9

// bus answers
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2

`endif

// file: verilog/i2c_mon_pkg.sv
// types shared by the two-wire bus status monitor
package i2c_mon_pkg;

  // the two bus lines travel together
  typedef struct packed {
    logic scl;
    logic sda;
  } line_s;

  // bus events, also the interrupt status layout
  typedef struct packed {
    logic ack;
    logic start;
    logic stop;
  } evt_s;

  // where the monitor stands within a transfer
  typedef enum logic [1:0] {
    ph_idle = 2'b00,
    ph_addr = 2'b01,
    ph_data = 2'b10
  } phase_e;

endpackage

// file: verilog/i2c_status_and_line_monitor.sv
// status flags, line levels and clock select of a two-wire bus unit, AXI4-Lite slave
`timescale 1ns/100ps
`include "i2c_mon_map.svh"
module i2c_status_and_line_monitor
  import i2c_mon_pkg::*;
#(
  parameter int ADDR_W = 18
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              serial_clock_pin,
  input  wire logic              serial_data_pin,
  output logic                   speed_select_bit,
  output logic                   glitch_filter_on,
  output logic                   rate_select_bit,
  output logic                   irq
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic              awready_r, wready_r, bvalid_r, arready_r, rvalid_r, irq_r;
  logic [1:0]        bresp_r, rresp_r;
  logic [31:0]       rdata_r, w_data_r, rd_word;
  logic [3:0]        w_strb_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic              aw_got_r, w_got_r, rd_hit;
  logic              aw_hs, w_hs, b_hs, ar_hs, r_hs, do_wr, wr_hit;
  logic [ADDR_W-3:0] widx, ridx;
  logic              en_r, rel_pulse, en_fall;
  logic [7:0]        clk_cfg_r;
  logic              cld_r, dad_r;
  evt_s              flag_r, ist_r, imask_r, ev;
  line_s             pins, lines;
  logic              scl_prev_r, sda_prev_r;
  logic              scl_rise, start_det, stop_det, mon_on, first_clk, ack_set;
  logic              addr_first, after_addr;
  phase_e            phase_r;
  logic [3:0]        cnt_r;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path: address and data taken in either order
  assign aw_hs  = awvalid & awready_r;
  assign w_hs   = wvalid & wready_r;
  assign b_hs   = bvalid_r & bready;
  assign do_wr  = aw_got_r & w_got_r & ~bvalid_r;
  assign widx   = aw_addr_r[ADDR_W-1:2];
  assign wr_hit = (widx == `IDX_CTRL) | (widx == `IDX_STATUS) | (widx == `IDX_CLKSEL) |
                  (widx == `IDX_INT_ST) | (widx == `IDX_INT_MASK);

  // hold address and data until both are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r  <= 1'b0;
      w_got_r   <= 1'b0;
      aw_addr_r <= '0;
      w_data_r  <= '0;
      w_strb_r  <= '0;
    end else begin
      if (aw_hs) begin
        aw_got_r  <= 1'b1;
        aw_addr_r <= awaddr;
      end else if (do_wr) begin
        aw_got_r <= 1'b0;
      end
      if (w_hs) begin
        w_got_r  <= 1'b1;
        w_data_r <= wdata;
        w_strb_r <= wstrb;
      end else if (do_wr) begin
        w_got_r <= 1'b0;
      end
    end
  end

  // readies drop on their handshake and return once the response is gone
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `RESP_OKAY;
    end else begin
      awready_r <= ~aw_hs & ~aw_got_r & ~bvalid_r & ~do_wr;
      wready_r  <= ~w_hs & ~w_got_r & ~bvalid_r & ~do_wr;
      if (do_wr) begin
        bvalid_r <= 1'b1;
        bresp_r  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (b_hs) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path
  assign ar_hs = arvalid & arready_r;
  assign r_hs  = rvalid_r & rready;
  assign ridx  = araddr[ADDR_W-1:2];
  // read mux; unused bits read as zero
  always_comb begin
    rd_word = '0;
    rd_hit  = 1'b1;
    case (ridx)
      `IDX_CTRL:     rd_word[`CTRL_EN_BIT] = en_r; // release reads back zero
      `IDX_STATUS:   rd_word[2:0] = flag_r;
      `IDX_CLKSEL: begin
        rd_word[7:0]        = clk_cfg_r;
        rd_word[`CLK_CLD_BIT] = cld_r;
        rd_word[`CLK_DAD_BIT] = dad_r;
      end
      `IDX_INT_ST:   rd_word[2:0] = ist_r;
      `IDX_INT_MASK: rd_word[2:0] = imask_r;
      default:       rd_hit = 1'b0;
    endcase
  end
  // one read in flight; data sampled at the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= '0;
      rresp_r   <= `RESP_OKAY;
    end else begin
      arready_r <= ~ar_hs & ~rvalid_r;
      if (ar_hs) begin
        rvalid_r <= 1'b1;
        rdata_r  <= rd_word;
        rresp_r  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (r_hs) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control and clock select registers
  assign rel_pulse = do_wr & w_strb_r[0] & (widx == `IDX_CTRL) & w_data_r[`CTRL_REL_BIT];
  assign en_fall   = do_wr & w_strb_r[0] & (widx == `IDX_CTRL) & en_r & ~w_data_r[`CTRL_EN_BIT];
  // unit enable; release is a write-one strobe and is not stored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_r <= 1'b0;
    end else if (do_wr && w_strb_r[0] && widx == `IDX_CTRL) begin
      en_r <= w_data_r[`CTRL_EN_BIT];
    end
  end
  // only speed, filter and rate bits are stored; level bits ignore writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_cfg_r <= `CLK_RESET;
    end else if (do_wr && w_strb_r[0] && widx == `IDX_CLKSEL) begin
      clk_cfg_r <= w_data_r[7:0] & `CLK_WR_MASK;
    end
  end
  assign speed_select_bit = clk_cfg_r[`CLK_SMC_BIT];
  assign glitch_filter_on = clk_cfg_r[`CLK_DFC_BIT];
  assign rate_select_bit  = clk_cfg_r[`CLK_CL0_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // line sampling and bus condition detection
  assign pins.scl = serial_clock_pin;
  assign pins.sda = serial_data_pin;
  line_sync u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pins    (pins),
    .lines   (lines)
  );
  // previous filtered levels for edge finding
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_prev_r <= 1'b1;
      sda_prev_r <= 1'b1;
    end else begin
      scl_prev_r <= lines.scl;
      sda_prev_r <= lines.sda;
    end
  end
  // conditions only count while the unit is enabled
  assign scl_rise   = lines.scl & ~scl_prev_r;
  assign start_det  = en_r & lines.scl & scl_prev_r & sda_prev_r & ~lines.sda;
  assign stop_det   = en_r & lines.scl & scl_prev_r & ~sda_prev_r & lines.sda;
  assign mon_on     = en_r & (phase_r != ph_idle);
  assign addr_first = mon_on & scl_rise & (phase_r == ph_addr) & (cnt_r == `CNT_ZERO);
  assign after_addr = mon_on & scl_rise & (phase_r == ph_addr) & (cnt_r == `CNT_LAST);
  assign first_clk  = mon_on & scl_rise & ((cnt_r == `CNT_ZERO) | (cnt_r == `CNT_LAST));
  assign ack_set    = mon_on & scl_rise & (cnt_r == `CNT_NINTH) & ~lines.sda;
  // clock count within a byte; a start or restart begins an address byte
  always_ff @(posedge aclk) begin
    if (!aresetn || !en_r) begin
      phase_r <= ph_idle;
      cnt_r   <= `CNT_ZERO;
    end else if (start_det) begin
      phase_r <= ph_addr;
      cnt_r   <= `CNT_ZERO;
    end else if (stop_det) begin
      phase_r <= ph_idle;
      cnt_r   <= `CNT_ZERO;
    end else if (mon_on && scl_rise) begin
      if (cnt_r == `CNT_LAST) begin
        cnt_r   <= `CNT_ONE;
        phase_r <= ph_data;
      end else begin
        cnt_r <= cnt_r + `CNT_ONE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status flags: hardware only, writes to the status index are ignored
  // ack flag; a set beats any clear except operation stop
  always_ff @(posedge aclk) begin
    if (!aresetn || en_fall) begin
      flag_r.ack <= 1'b0;
    end else if (ack_set) begin
      flag_r.ack <= 1'b1;
    end else if (stop_det || first_clk || rel_pulse) begin
      flag_r.ack <= 1'b0;
    end
  end
  // start flag marks the address transfer period
  always_ff @(posedge aclk) begin
    if (!aresetn || en_fall) begin
      flag_r.start <= 1'b0;
    end else if (start_det) begin
      flag_r.start <= 1'b1;
    end else if (stop_det || after_addr || rel_pulse) begin
      flag_r.start <= 1'b0;
    end
  end
  // stop flag means bus free; an address phase implies a start after the stop
  always_ff @(posedge aclk) begin
    if (!aresetn || en_fall) begin
      flag_r.stop <= 1'b0;
    end else if (stop_det) begin
      flag_r.stop <= 1'b1;
    end else if (addr_first) begin
      flag_r.stop <= 1'b0;
    end
  end
  // line levels, forced low while stopped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cld_r <= 1'b0;
      dad_r <= 1'b0;
    end else begin
      cld_r <= en_r & lines.scl;
      dad_r <= en_r & lines.sda;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts: sticky events, cleared by reading, masked onto one level
  assign ev.ack   = ack_set;
  assign ev.start = start_det;
  assign ev.stop  = stop_det;

  // an event in the clearing read cycle survives
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ist_r <= '0;
    end else begin
      ist_r <= ((ar_hs && ridx == `IDX_INT_ST) ? evt_s'(3'h0) : ist_r) | ev;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      imask_r <= '0;
      irq_r   <= 1'b0;
    end else begin
      if (do_wr && w_strb_r[0] && widx == `IDX_INT_MASK) begin
        imask_r <= w_data_r[2:0];
      end
      irq_r <= |(ist_r & imask_r);
    end
  end
  assign awready = awready_r;
  assign wready  = wready_r;
  assign bvalid  = bvalid_r;
  assign bresp   = bresp_r;
  assign arready = arready_r;
  assign rvalid  = rvalid_r;
  assign rdata   = rdata_r;
  assign rresp   = rresp_r;
  assign irq     = irq_r;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_ack_set_ninth: assert property (ack_set && !en_fall |=> flag_r.ack)
    else $error("ack flag not set at ninth clock");
  a_ack_clr_stop: assert property (stop_det |=> !flag_r.ack)
    else $error("ack flag survived a stop");
  a_start_set_det: assert property (start_det && !en_fall |=> flag_r.start)
    else $error("start flag not set on start");
  a_start_clr_addr: assert property (after_addr && !start_det |=>
    !flag_r.start ##1 (!flag_r.start || start_det))
    else $error("start flag kept after address byte");
  a_stop_set_det: assert property (stop_det && !en_fall |=>
    flag_r.stop ##1 (flag_r.stop || $past(en_fall)))
    else $error("stop flag not set on stop");
  a_stop_clr_stop_unit: assert property (en_r ##1 !en_r |-> flag_r == evt_s'(3'h0))
    else $error("flags kept after operation stop");
  a_scl_level_track: assert property (##1 cld_r == ($past(en_r) & $past(lines.scl)))
    else $error("clock line level wrong");
  a_sda_level_off: assert property (!en_r [*2] |-> !dad_r)
    else $error("data line level shown while stopped");
  a_speed_hold: assert property (!(do_wr && widx == `IDX_CLKSEL) |=> $stable(speed_select_bit))
    else $error("speed select changed without write");

  c_ack_seen: cover property (ack_set ##[1:500] stop_det);
  c_restart: cover property (start_det ##[1:1000] start_det);
  c_release: cover property (flag_r.start && rel_pulse);
  c_irq_clear: cover property (irq_r ##[1:20] !irq_r);

endmodule // i2c_status_and_line_monitor

// file: verilog/line_sync.sv
// three-stage synchroniser with agreement filter for the bus lines
`timescale 1ns/100ps
module line_sync
  import i2c_mon_pkg::*;
(
  input  wire logic  aclk,
  input  wire logic  aresetn,
  input  wire line_s pins,
  output line_s      lines
);

  localparam int W = $bits(line_s);

  // per line: ff1 feeds ff2 only; a level is taken once ff2 and ff3 agree
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic ff1_r;
    logic ff2_r;
    logic ff3_r;
    logic q_r;
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        ff1_r <= 1'b1;
        ff2_r <= 1'b1;
        ff3_r <= 1'b1;
        q_r   <= 1'b1; // idle bus is pulled high
      end else begin
        ff1_r <= pins[i];
        ff2_r <= ff1_r;
        ff3_r <= ff2_r;
        if (ff2_r == ff3_r) begin
          q_r <= ff3_r;
        end
      end
    end
    assign lines[i] = q_r;
  end

endmodule // line_sync
